// ==== rtl/clock_mode_pkg.sv ====
// constants shared by the core clock mode selector
// assumes a single fast sampling clock and an apb register port
package clock_mode_pkg;
   // apb geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_RESTART = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_PERIOD = 12'h00C;
   // reset configuration latch layout
   localparam int CFG_W = 8;
   localparam int SEL_MSB = 7;
   localparam int SEL_LSB = 5;
   localparam logic [CFG_W-1:0] CFG_RESET = 8'hFF;
   // restart control register layout
   localparam int RESTART_HI_LSB = 8;
   localparam int RESTART_LOAD_BIT = 0;
   localparam logic [CFG_W-1:0] RESTART_RESET = 8'hFF;
   // clock mode select codes
   localparam logic [2:0] SEL_X4 = 3'h7;
   localparam logic [2:0] SEL_X3 = 3'h6;
   localparam logic [2:0] SEL_X2 = 3'h5;
   localparam logic [2:0] SEL_X5 = 3'h4;
   localparam logic [2:0] SEL_DIRECT = 3'h3;
   localparam logic [2:0] SEL_X1P5 = 3'h2;
   localparam logic [2:0] SEL_PRESCALE = 3'h1;
   localparam logic [2:0] SEL_X2P5 = 3'h0;
   // half-cycles per oscillator period, twice the factor
   localparam logic [3:0] HALVES_X4 = 4'h8;
   localparam logic [3:0] HALVES_X3 = 4'h6;
   localparam logic [3:0] HALVES_X2 = 4'h4;
   localparam logic [3:0] HALVES_X5 = 4'hA;
   localparam logic [3:0] HALVES_X1P5 = 4'h3;
   localparam logic [3:0] HALVES_X2P5 = 4'h5;
   // strap capture waits for the pin synchroniser to fill
   localparam logic [1:0] STRAP_DELAY = 2'h3;
   // measurement and synthesis widths
   localparam int PERIOD_W = 16;
   localparam int ACC_W = 20;
   // clock source kinds
   typedef enum logic [1:0] {
      SRC_PRESCALE = 2'b00,
      SRC_DIRECT = 2'b01,
      SRC_PLL = 2'b11
   } clk_src_t;
endpackage

// ==== rtl/cpu_clock_mode_select.sv ====
// core clock mode selector: strap latch, software reload and core clock synthesis
// assumes clk samples the oscillator pin many times per oscillator period
// What this block does
// R01: the core clock carries actions on both edges, one edge to edge span being a half-cycle.
// R02: the generation mechanism is picked by latch bits 7 down to 5.
// R03: after a long hardware reset the latch holds the upper port0 pin levels.
// R04: software may reload the latch from the upper byte of the restart control register.
// R05: the select code maps to x4, x3, x2, x5, direct, x1.5, half and x2.5.
// R06: code 001 halves the oscillator, each core phase lasting one oscillator period.
// R07: multiplying codes run the loop at F times and resync it every F oscillator transitions, F rounded up.
// R08: loop resync and tracking move the core clock gradually, never abruptly.
// R09: code 011 stops the loop and lets the core clock follow the oscillator level.
// R10: in direct drive two neighbouring half-cycles always add up to one oscillator period.
// R11: the selected mode and a half-cycle phase marker are presented to downstream logic.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_mode_select
   import clock_mode_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [clock_mode_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [clock_mode_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [clock_mode_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_in,
   input wire logic [clock_mode_pkg::CFG_W-1:0] port0_upper_pins,
   output logic core_clk,
   output logic core_rise,
   output logic core_fall,
   output logic half_phase,
   output logic [2:0] clock_mode_select,
   output logic pll_enable,
   output logic pll_locked
);
   import clock_mode_pkg::*;

   typedef struct packed {
      logic [CFG_W-1:0] pin_s1;
      logic [CFG_W-1:0] pin_s2;
      logic osc_s1;
      logic osc_s2;
      logic osc_d;
      logic [1:0] boot_cnt;
      logic [CFG_W-1:0] config_latch;
      logic [CFG_W-1:0] restart_hi;
      logic [PERIOD_W-1:0] period_cnt;
      logic [PERIOD_W-1:0] period_est;
      logic [ACC_W-1:0] acc;
      logic [3:0] trans_cnt;
      logic locked;
      logic core_clk;
      logic core_rise;
      logic core_fall;
      logic half_phase;
      logic [DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
      logic pll_en;
   } state_t;

   state_t st_ff;
   state_t nxt_st;

   // source kind for a select code
   function automatic clk_src_t src_of(input logic [2:0] sel);
      if (sel == SEL_PRESCALE)
      begin
         return SRC_PRESCALE;
      end
      else if (sel == SEL_DIRECT)
      begin
         return SRC_DIRECT;
      end
      return SRC_PLL;
   endfunction

   // half-cycles per oscillator period for a multiplying code
   function automatic logic [3:0] halves_of(input logic [2:0] sel);
      logic [3:0] h;
      h = HALVES_X4;
      case (sel)
         SEL_X3: h = HALVES_X3;
         SEL_X2: h = HALVES_X2;
         SEL_X5: h = HALVES_X5;
         SEL_X1P5: h = HALVES_X1P5;
         SEL_X2P5: h = HALVES_X2P5;
         default: h = HALVES_X4;
      endcase
      return h;
   endfunction

   logic [2:0] sel;
   clk_src_t src;
   logic [3:0] halves;
   logic [3:0] resync_at;
   logic osc_rise;
   logic osc_edge;
   logic toggle;
   logic [PERIOD_W-1:0] measured;
   logic [ACC_W:0] sum;
   logic [ACC_W:0] pulled;
   logic bus_setup;
   logic bus_write;

   // next state of the whole block
   always_comb
   begin
      nxt_st = st_ff;
      toggle = 1'b0;
      measured = '0;
      sum = '0;
      pulled = '0;
      nxt_st.core_rise = 1'b0;
      nxt_st.core_fall = 1'b0;

      // two-flop synchronisers for the pins
      nxt_st.pin_s1 = port0_upper_pins;
      nxt_st.pin_s2 = st_ff.pin_s1;
      nxt_st.osc_s1 = osc_in;
      nxt_st.osc_s2 = st_ff.osc_s1;
      nxt_st.osc_d = st_ff.osc_s2;
      osc_rise = st_ff.osc_s2 & ~st_ff.osc_d;
      osc_edge = st_ff.osc_s2 ^ st_ff.osc_d;

      // strap capture once the synchroniser holds settled pins
      if (st_ff.boot_cnt != STRAP_DELAY)
      begin
         nxt_st.boot_cnt = st_ff.boot_cnt + 2'h1;
         if (st_ff.boot_cnt == STRAP_DELAY - 2'h1)
         begin
            nxt_st.config_latch = st_ff.pin_s2; // see R03
         end
      end

      // mode decode from the latch field
      sel = st_ff.config_latch[SEL_MSB:SEL_LSB]; // see R02
      src = src_of(sel); // see R05
      halves = halves_of(sel); // see R05
      resync_at = (halves + 4'h1) >> 1;

      // oscillator period measured in sampling clocks
      if (osc_rise)
      begin
         measured = st_ff.period_cnt + 16'h0001;
         nxt_st.period_cnt = '0;
         if (st_ff.period_est == '0)
         begin
            nxt_st.period_est = measured;
         end
         else if (measured > st_ff.period_est)
         begin
            nxt_st.period_est = st_ff.period_est + 16'h0001; // see R08
         end
         else if (measured < st_ff.period_est)
         begin
            nxt_st.period_est = st_ff.period_est - 16'h0001; // see R08
         end
         nxt_st.locked = (src == SRC_PLL) && (measured == st_ff.period_est);
      end
      else if (st_ff.period_cnt != '1)
      begin
         nxt_st.period_cnt = st_ff.period_cnt + 16'h0001;
      end

      // core clock generation per source
      case (src)
         SRC_PRESCALE:
         begin
            // one core phase per oscillator period
            toggle = osc_rise; // see R06
            nxt_st.acc = '0;
            nxt_st.trans_cnt = '0;
            nxt_st.locked = 1'b0;
         end
         SRC_DIRECT:
         begin
            // core level tracks the oscillator level
            toggle = st_ff.osc_s2 != st_ff.core_clk; // see R09 R10
            nxt_st.acc = '0;
            nxt_st.trans_cnt = '0;
            nxt_st.locked = 1'b0;
         end
         default:
         begin
            // digital loop: halves toggles per estimated period
            if (st_ff.period_est != '0)
            begin
               sum = {1'b0, st_ff.acc} + {{(ACC_W-3){1'b0}}, halves};
               if (sum >= {{(ACC_W-PERIOD_W+1){1'b0}}, st_ff.period_est})
               begin
                  sum = sum - {{(ACC_W-PERIOD_W+1){1'b0}}, st_ff.period_est};
                  toggle = 1'b1; // see R07
               end
               nxt_st.acc = sum[ACC_W-1:0];
            end
            // resync every F oscillator transitions, F rounded up, pulling phase by half
            if (osc_edge)
            begin
               if (st_ff.trans_cnt + 4'h1 >= resync_at)
               begin
                  nxt_st.trans_cnt = '0;
                  // pull the phase halfway to the nearer toggle point, no rate loss
                  if (sum >= {{(ACC_W-PERIOD_W+2){1'b0}}, st_ff.period_est[PERIOD_W-1:1]})
                  begin
                     pulled = sum + {{(ACC_W-PERIOD_W+1){1'b0}}, st_ff.period_est};
                     nxt_st.acc = pulled[ACC_W:1]; // see R07 R08
                  end
                  else
                  begin
                     nxt_st.acc = sum[ACC_W:1]; // see R07 R08
                  end
               end
               else
               begin
                  nxt_st.trans_cnt = st_ff.trans_cnt + 4'h1;
               end
            end
         end
      endcase

      // edge markers for both-edge sequencing
      if (toggle)
      begin
         nxt_st.core_clk = ~st_ff.core_clk;
         nxt_st.core_rise = ~st_ff.core_clk; // see R01
         nxt_st.core_fall = st_ff.core_clk; // see R01
         nxt_st.half_phase = ~st_ff.half_phase; // see R11
      end

      // apb slave, answer in the first access cycle
      bus_setup = psel & ~penable;
      bus_write = psel & penable & pwrite & st_ff.pready;
      nxt_st.pready = bus_setup;
      if (bus_setup)
      begin
         nxt_st.prdata = '0;
         nxt_st.pslverr = 1'b0;
         if (paddr == OFS_CONFIG)
         begin
            nxt_st.prdata[CFG_W-1:0] = st_ff.config_latch;
         end
         else if (paddr == OFS_RESTART)
         begin
            nxt_st.prdata[RESTART_HI_LSB+CFG_W-1:RESTART_HI_LSB] = st_ff.restart_hi;
         end
         else if (paddr == OFS_STATUS)
         begin
            nxt_st.prdata[2:0] = sel; // see R11
            nxt_st.prdata[3] = st_ff.core_clk;
            nxt_st.prdata[4] = st_ff.half_phase;
            nxt_st.prdata[5] = (src == SRC_PLL);
            nxt_st.prdata[6] = st_ff.locked;
         end
         else if (paddr == OFS_PERIOD)
         begin
            nxt_st.prdata[PERIOD_W-1:0] = st_ff.period_est;
         end
         else
         begin
            nxt_st.pslverr = 1'b1;
         end
      end
      else if (psel & penable & st_ff.pready)
      begin
         nxt_st.prdata = '0;
         nxt_st.pslverr = 1'b0;
      end

      // restart control write and software reload of the latch
      if (bus_write && paddr == OFS_RESTART)
      begin
         if (pstrb[1])
         begin
            nxt_st.restart_hi = pwdata[RESTART_HI_LSB+CFG_W-1:RESTART_HI_LSB];
         end
         if (pstrb[0] && pwdata[RESTART_LOAD_BIT])
         begin
            nxt_st.config_latch = pstrb[1]
               ? pwdata[RESTART_HI_LSB+CFG_W-1:RESTART_HI_LSB]
               : st_ff.restart_hi; // see R04
         end
      end

      // loop enable follows the latch value of the coming cycle
      nxt_st.pll_en = nxt_st.config_latch[SEL_MSB:SEL_LSB] != SEL_DIRECT
         && nxt_st.config_latch[SEL_MSB:SEL_LSB] != SEL_PRESCALE; // see R07 R09
   end

   // state register
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         st_ff <= '0;
         st_ff.config_latch <= CFG_RESET;
         st_ff.restart_hi <= RESTART_RESET;
         st_ff.pll_en <= 1'b1;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from the state flops
   assign prdata = st_ff.prdata;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign core_clk = st_ff.core_clk;
   assign core_rise = st_ff.core_rise;
   assign core_fall = st_ff.core_fall;
   assign half_phase = st_ff.half_phase;
   assign clock_mode_select = st_ff.config_latch[SEL_MSB:SEL_LSB];
   assign pll_enable = st_ff.pll_en; // see R09
   assign pll_locked = st_ff.locked;
endmodule
`default_nettype wire

// ==== tb/osc_source_model.sv ====
// free running oscillator feeding the clock selector
// assumes high and low times in ns set by the bench
`timescale 1ns/1ps
`default_nettype none
module osc_source_model
(
   input wire logic [15:0] high_ns,
   input wire logic [15:0] low_ns,
   output logic osc_in
);
   // odd start offset keeps edges unrelated to clk
   initial
   begin
      osc_in = 1'b0;
      #17;
      forever
      begin
         osc_in = 1'b1;
         #(high_ns);
         osc_in = 1'b0;
         #(low_ns);
      end
   end
endmodule
`default_nettype wire

// ==== tb/cpu_clock_mode_select_monitor.sv ====
// port checker for the core clock mode selector
// assumes it is bound onto cpu_clock_mode_select
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_mode_select_monitor
   import clock_mode_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [clock_mode_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic osc_in,
   input wire logic core_clk,
   input wire logic core_rise,
   input wire logic core_fall,
   input wire logic half_phase,
   input wire logic [2:0] clock_mode_select,
   input wire logic pll_enable
);
   logic [3:0] age_ff;
   logic wr;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // cycles since reset release, saturating
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         age_ff <= 4'h0;
      else if (age_ff != 4'hF)
         age_ff <= age_ff + 4'h1;
   end
   // restart register write in its access cycle
   assign wr = psel && penable && pwrite && pready && paddr == OFS_RESTART;
   chk_rise_pulse: assert property ($rose(core_clk) |-> core_rise)
      else $error("rise pulse missing");
   chk_fall_pulse: assert property ($fell(core_clk) |-> core_fall)
      else $error("fall pulse missing");
   chk_loop_enable: assert property (pll_enable == !(clock_mode_select inside {3'h3, 3'h1}))
      else $error("loop enable wrong for mode");
   chk_apb_answer: assert property (psel && !penable |=> pready)
      else $error("no answer in access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_mode_cause: assert property ($changed(clock_mode_select) && age_ff == 4'hF
      |-> $past(wr) || $past(wr, 2))
      else $error("mode changed without reload");
   chk_direct_follow: assert property ((clock_mode_select == SEL_DIRECT && $stable(osc_in)
      && $stable(clock_mode_select))[*6] |-> core_clk == osc_in)
      else $error("direct clock not following");
   chk_prescale_hold: assert property ((clock_mode_select == SEL_PRESCALE && $stable(osc_in)
      && $stable(clock_mode_select))[*6] |-> $stable(core_clk))
      else $error("prescaled clock moved");
   chk_phase_marker: assert property ($changed(half_phase) == (core_rise || core_fall))
      else $error("phase marker out of step with core edges");
endmodule
bind cpu_clock_mode_select cpu_clock_mode_select_monitor mon (.clk(clk), .reset(reset),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
   .osc_in(osc_in), .core_clk(core_clk), .core_rise(core_rise), .core_fall(core_fall),
   .half_phase(half_phase), .clock_mode_select(clock_mode_select), .pll_enable(pll_enable));
`default_nettype wire

// ==== tb/test_cpu_clock_mode_select.sv ====
// self-checking bench for the core clock mode selector
// assumes the oscillator model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module test_cpu_clock_mode_select;
   import clock_mode_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [ADDR_W-1:0] paddr = '0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [3:0] pstrb = 4'h0;
   logic [DATA_W-1:0] prdata, rd;
   logic pready, pslverr, err, osc_in, core_clk, core_rise, core_fall;
   logic half_phase, pll_enable, pll_locked;
   logic [2:0] clock_mode_select;
   logic [7:0] pins = 8'h6B;
   logic [15:0] high_ns = 16'd1000;
   logic [15:0] low_ns = 16'd1000;
   logic [3:0] halves [8] = '{4'h5, 4'h1, 4'h3, 4'h2, 4'hA, 4'h4, 4'h6, 4'h8};
   int failures = 0;
   int tests_run = 0;
   int n;
   int m;
   always #25 clk = ~clk;
   osc_source_model osc (.high_ns(high_ns), .low_ns(low_ns), .osc_in(osc_in));
   cpu_clock_mode_select dut (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .osc_in(osc_in), .port0_upper_pins(pins),
      .core_clk(core_clk), .core_rise(core_rise), .core_fall(core_fall),
      .half_phase(half_phase), .clock_mode_select(clock_mode_select),
      .pll_enable(pll_enable), .pll_locked(pll_locked));
   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
   begin
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   end
   endtask
   // one apb transfer, waits for pready
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int t;
   begin
      t = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1 && ++t < 20);
      if (t == 20)
         failures++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   // count core rises and phase marker flips over a span of clk cycles
   task automatic rises(input int cyc);
      logic last;
   begin
      n = 0;
      m = 0;
      last = half_phase;
      repeat (cyc)
      begin
         @(posedge clk);
         n += int'(core_rise === 1'b1);
         m += int'(half_phase !== last);
         last = half_phase;
      end
   end
   endtask
   // cycles from a core rise to the next fall or rise
   task automatic span(input logic to_fall);
      int t;
   begin
      t = 0;
      n = 0;
      do
         @(posedge clk);
      while (core_rise !== 1'b1 && ++t < 400);
      do
         @(posedge clk);
      while ((to_fall ? core_fall : core_rise) !== 1'b1 && ++n < 400);
      n++;
   end
   endtask
   task automatic conclude();
   begin
      if (failures == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask
   // watchdog well beyond the expected run
   initial
   begin
      #1000000;
      failures++;
      conclude();
   end
   // main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      repeat (6) @(posedge clk);
      apb(1'b0, OFS_CONFIG, '0, 4'h0);
      check(rd, 32'h0000006B);
      check({29'h0, clock_mode_select}, 32'h3);
      apb(1'b0, OFS_RESTART, '0, 4'h0);
      check(rd, 32'h0000FF00);
      apb(1'b1, OFS_CONFIG, '0, 4'hF);
      apb(1'b0, 12'h010, '0, 4'h0);
      check({rd[31:1], err}, 32'h1);
      apb(1'b0, OFS_CONFIG, '0, 4'h0);
      check(rd, 32'h0000006B);
      high_ns <= 16'd500;
      low_ns <= 16'd1500;
      repeat (200) @(posedge clk);
      span(1'b1);
      check(n, 10);
      span(1'b0);
      check(n, 40);
      high_ns <= 16'd1000;
      low_ns <= 16'd1000;
      for (int c = 0; c < 8; c++)
      begin
         apb(1'b1, OFS_RESTART, {16'h0, 3'(c), 5'h0A, 8'h01}, 4'h3);
         apb(1'b0, OFS_CONFIG, '0, 4'h0);
         check(rd, {24'h0, 3'(c), 5'h0A});
         check({29'h0, clock_mode_select}, 32'(c));
         check({31'h0, pll_enable}, {31'h0, c != 3 && c != 1});
         repeat (480) @(posedge clk);
         rises(320);
         check({31'h0, n >= halves[c] * 4 - 1 && n <= halves[c] * 4 + 1}, 32'h1);
         check({31'h0, m >= 2 * n - 1 && m <= 2 * n + 1}, 32'h1);
         if (c != 3 && c != 1)
            check({31'h0, pll_locked}, 32'h1);
         if (c == 1)
         begin
            span(1'b1);
            check(n, 40);
         end
      end
      apb(1'b1, OFS_RESTART, 32'h0000E000, 4'h2);
      apb(1'b1, OFS_RESTART, 32'h00000001, 4'h1);
      apb(1'b0, OFS_CONFIG, '0, 4'h0);
      check(rd, 32'h000000E0);
      apb(1'b0, OFS_STATUS, '0, 4'h0);
      check({rd[31:7], rd[6:5], 2'h0, rd[2:0]}, 32'h00000067);
      apb(1'b0, OFS_PERIOD, '0, 4'h0);
      check(rd, 32'((high_ns + low_ns) / 16'd50));
      // second reset with other strap levels
      pins <= 8'hA5;
      reset <= 1'b1;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      repeat (6) @(posedge clk);
      apb(1'b0, OFS_CONFIG, '0, 4'h0);
      check(rd, 32'h000000A5);
      check({29'h0, clock_mode_select}, 32'h5);
      conclude();
   end
endmodule
`default_nettype wire
